// ---- testbench/dma_periph_model.sv ----
// peripheral side model: request pins and terminal count pulses
`timescale 1ns/1ps
module dma_periph_model (
  input  wire logic       sys_clk,
  input  wire logic       req_active_low,
  output logic      [3:0] dma_request_line,
  output logic      [3:0] chan_count_done
);
  // ==========================================================
  // request pins
  logic [3:0] want_q;  // channels that want service
  // pin level follows the sense that software has chosen
  assign dma_request_line = req_active_low ? ~want_q : want_q;
  initial begin
    want_q = 4'h0;
    chan_count_done = 4'h0;
  end
  // change the wanted set just after a clock edge
  task set_req(input logic [3:0] m);
    @(posedge sys_clk);
    #1 want_q = m;
  endtask : set_req
  // one-cycle terminal count pulse on one channel
  task pulse_done(input int ch);
    @(posedge sys_clk);
    #1 chan_count_done = 4'h1 << ch;
    @(posedge sys_clk);
    #1 chan_count_done = 4'h0;
  endtask : pulse_done
endmodule : dma_periph_model

// ---- testbench/tb_upper_dma_channel_control.sv ----
// self-checking bench for the upper dma channel control block
`timescale 1ns/1ps
module tb_upper_dma_channel_control;
  import upper_dma_pkg::*;
  // ==========================================================
  // signals
  logic        sys_clk, reset_n, io_write, io_read, req_low;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, rv, dmode, dtype;
  logic [3:0]  req_pins, tc_pins, ack, gnt, ddir, dauto;
  logic [7:0]  tmode, ttype;
  logic [3:0]  adec, ainit;
  logic        ext_wr, comp, bptr;
  int          num_errors, checked, cycles;
  initial sys_clk = 1'b0;
  always #2.5 sys_clk = ~sys_clk;
  dma_periph_model periph (.sys_clk(sys_clk), .req_active_low(req_low),
    .dma_request_line(req_pins), .chan_count_done(tc_pins));
  upper_dma_channel_control dut (.sys_clk(sys_clk), .reset_n(reset_n),
    .io_addr(io_addr), .io_wdata(io_wdata), .io_write(io_write),
    .io_read(io_read), .io_rdata(io_rdata),
    .dma_request_line(req_pins), .chan_count_done(tc_pins),
    .dma_acknowledge(ack), .chan_granted(gnt), .extended_write(ext_wr),
    .cycle_compression(comp), .byte_pointer_high(bptr),
    .transfer_mode_field(tmode), .address_decrement(adec),
    .auto_init_enable(ainit), .transfer_type_field(ttype));
  // ==========================================================
  // bus tasks: strobe for one edge, then let outputs settle
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 io_addr = a;
    io_wdata = d;
    io_write = 1'b1;
    @(posedge sys_clk);
    #1 io_write = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : wr
  task rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    #1 io_addr = a;
    io_read = 1'b1;
    @(posedge sys_clk);
    #1 io_read = 1'b0;
    d = io_rdata;
  endtask : rd
  task settle;
    repeat (5) @(posedge sys_clk);
    #1;
  endtask : settle
  // ==========================================================
  // compare and report
  task chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task done_test(input string n);
    $display("test %s finished, errors so far %0d", n, num_errors);
  endtask : done_test
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  // cut a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("timeout after %0d cycles", cycles);
      wrap_up();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {num_errors, checked, cycles} = '0;
    {io_write, io_read, req_low} = 3'b000;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    reset_n = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    // reset state, masks all set, unmapped read
    chk("ack", 8'h0F, {4'h0, ack});
    chk("grant", 8'h00, {4'h0, gnt});
    chk("modes", 8'h00, tmode | ttype);
    rd(ADDR_COMMAND, rv);
    chk("status", 8'h00, rv);
    rd(16'h0040, rv);
    chk("unmapped", 8'h00, rv);
    wr(ADDR_SOFT_REQ, 8'h04);
    chk("masked grant", 8'h00, {4'h0, gnt});
    rd(ADDR_COMMAND, rv);
    chk("pending", 8'h10, rv);
    wr(ADDR_SOFT_REQ, 8'h00);
    rd(ADDR_COMMAND, rv);
    chk("withdrawn", 8'h00, rv);
    done_test("reset");
    // unmask, soft request with junk upper bits, command bits
    wr(ADDR_ALL_MASK, 8'hF0);
    wr(ADDR_SOFT_REQ, 8'hFD);
    chk("grant5", 8'h02, {4'h0, gnt});
    chk("ack low", 8'h0D, {4'h0, ack});
    wr(ADDR_COMMAND, 8'h82);
    chk("ack high", 8'h02, {4'h0, ack});
    wr(ADDR_COMMAND, 8'hA8);
    chk("timing", 8'h03, {6'h0, ext_wr, comp});
    wr(ADDR_COMMAND, 8'h84);
    chk("disabled", 8'h00, {gnt, ack});
    wr(ADDR_COMMAND, 8'h80);
    chk("enabled", 8'h22, {gnt, ack});
    wr(ADDR_SINGLE_MASK, 8'hFD);
    chk("mask5", 8'h00, {4'h0, gnt});
    wr(ADDR_SINGLE_MASK, 8'h01);
    chk("unmask5", 8'h02, {4'h0, gnt});
    done_test("command");
    // fixed then rotating priority after channel 5 is served
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_COMMAND, p ? 8'h10 : 8'h00);
      chk("held5", 8'h02, {4'h0, gnt});
      wr(ADDR_SOFT_REQ, 8'h04);
      wr(ADDR_SOFT_REQ, 8'h06);
      chk("stays", 8'h02, {4'h0, gnt});
      wr(ADDR_SOFT_REQ, 8'h01);
      chk("next", p ? 8'h04 : 8'h01, {4'h0, gnt});
      wr(ADDR_SOFT_REQ, 8'h00);
      wr(ADDR_SOFT_REQ, 8'h02);
      wr(ADDR_SOFT_REQ, 8'h05);
    end
    wr(ADDR_SOFT_REQ, 8'h01);
    wr(ADDR_COMMAND, 8'h00);
    done_test("priority");
    // pin request, terminal count flags, request sense
    periph.set_req(4'h8);
    settle();
    chk("pin grant", 8'h08, {4'h0, gnt});
    periph.pulse_done(2);
    rd(ADDR_COMMAND, rv);
    chk("tc flag", 8'h84, rv);
    rd(ADDR_COMMAND, rv);
    chk("tc cleared", 8'h80, rv);
    req_low = 1'b1;
    wr(ADDR_COMMAND, 8'h40);
    chk("low sense", 8'h08, {4'h0, gnt});
    periph.set_req(4'h0);
    settle();
    chk("no pin", 8'h00, {4'h0, gnt});
    wr(ADDR_COMMAND, 8'h00);
    req_low = 1'b0;
    settle();
    done_test("pins");
    // one mode byte per channel, every mode and legal type
    {dmode, dtype, ddir, dauto} = '0;
    for (int i = 0; i < 4; i++) begin
      dmode[2*i +: 2] = i[1:0];
      dtype[2*i +: 2] = 2'(i % 3);
      ddir[i] = i[0];
      dauto[i] = i[1];
      wr(ADDR_MODE, {i[1:0], i[0], i[1], 2'(i % 3), i[1:0]});
    end
    chk("xfer mode", dmode, tmode);
    chk("direction", {4'h0, ddir}, {4'h0, adec});
    chk("auto init", {4'h0, dauto}, {4'h0, ainit});
    chk("xfer type", dtype, ttype);
    done_test("mode");
    // byte pointer steps and clears
    wr(ADDR_XFER_LO, 8'h12);
    chk("ptr hi", 8'h01, {7'h0, bptr});
    rd(16'h00C2, rv);
    #1 chk("ptr lo", 8'h00, {7'h0, bptr});
    wr(16'h00C4, 8'h34);
    wr(ADDR_PTR_CLEAR, 8'h5A);
    chk("ptr clear", 8'h00, {7'h0, bptr});
    done_test("pointer");
    // unmask-all, then full reset restores command, masks, soft requests, modes, pointer and flags
    wr(ADDR_ALL_MASK, 8'h0F);
    wr(ADDR_SOFT_REQ, 8'h04);
    chk("all masked", 8'h00, {4'h0, gnt});
    wr(ADDR_UNMASK_ALL, 8'h77);
    chk("unmask all", 8'h01, {4'h0, gnt});
    wr(ADDR_COMMAND, 8'hA8);
    wr(ADDR_XFER_LO, 8'h00);
    wr(ADDR_FULL_RESET, 8'h3C);
    chk("clr cmd", 8'h00, {6'h0, ext_wr, comp});
    chk("clr grant", 8'h0F, {gnt, ack});
    chk("clr ptr", 8'h00, {7'h0, bptr});
    chk("clr mode", 8'h00, tmode | ttype);
    rd(ADDR_COMMAND, rv);
    chk("clr status", 8'h00, rv);
    done_test("clear");
    // asynchronous reset in mid-run restores the idle state
    wr(ADDR_UNMASK_ALL, 8'h00);
    wr(ADDR_SOFT_REQ, 8'h04);
    chk("pre reset", 8'h1E, {gnt, ack});
    reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    chk("reset idle", 8'h0F, {gnt, ack});
    rd(ADDR_COMMAND, rv);
    chk("reset status", 8'h00, rv);
    done_test("async reset");
    wrap_up();
  end
endmodule : tb_upper_dma_channel_control

// ---- verilog/upper_dma_channel_control.sv ----
// control, masking, mode and arbitration of the upper four dma channels
`timescale 1ns/1ps
module upper_dma_channel_control #(
  parameter int NCH = 4
) (
  input  wire logic                        sys_clk,
  input  wire logic                        reset_n,
  input  wire logic [upper_dma_pkg::ADDR_W-1:0] io_addr,
  input  wire logic [7:0]                  io_wdata,
  input  wire logic                        io_write,
  input  wire logic                        io_read,
  output logic      [7:0]                  io_rdata,
  input  wire logic [NCH-1:0]              dma_request_line,
  input  wire logic [NCH-1:0]              chan_count_done,
  output logic      [NCH-1:0]              dma_acknowledge,
  output logic      [NCH-1:0]              chan_granted,
  output logic                             extended_write,
  output logic                             cycle_compression,
  output logic                             byte_pointer_high,
  output logic      [2*NCH-1:0]            transfer_mode_field,
  output logic      [NCH-1:0]              address_decrement,
  output logic      [NCH-1:0]              auto_init_enable,
  output logic      [2*NCH-1:0]            transfer_type_field
);
  import upper_dma_pkg::*;

  // ==========================================================
  // address decode
  logic            wr_command;     // command byte write
  logic            wr_soft_req;    // software request write
  logic            wr_single_mask; // single channel mask write
  logic            wr_mode;        // mode write
  logic            wr_ptr_clear;   // byte pointer reset
  logic            full_reset;     // controller_full_reset strobe
  logic            unmask_all_strobe;
  logic            wr_all_mask;    // all-channel mask write
  logic            xfer_access;    // address/count byte access
  logic            rd_status;      // status read
  logic [1:0]      channel_selector;
  logic [NCH-1:0]  sel_onehot;     // decoded channel select

  assign wr_command       = io_write && (io_addr == ADDR_COMMAND);
  assign wr_soft_req      = io_write && (io_addr == ADDR_SOFT_REQ);
  assign wr_single_mask   = io_write && (io_addr == ADDR_SINGLE_MASK);
  assign wr_mode          = io_write && (io_addr == ADDR_MODE);
  assign wr_ptr_clear     = io_write && (io_addr == ADDR_PTR_CLEAR);
  assign full_reset       = io_write && (io_addr == ADDR_FULL_RESET);
  assign unmask_all_strobe = io_write && (io_addr == ADDR_UNMASK_ALL);
  assign wr_all_mask      = io_write && (io_addr == ADDR_ALL_MASK);
  assign rd_status        = io_read && (io_addr == ADDR_COMMAND);
  // even addresses in the window are the channel byte registers
  assign xfer_access      = (io_write || io_read) &&
                            (io_addr >= ADDR_XFER_LO) &&
                            (io_addr <= ADDR_XFER_HI) && !io_addr[0];
  // only bits 1:0 choose the channel, upper bits are dropped
  assign channel_selector = io_wdata[SEL_MSB:SEL_LSB];
  assign sel_onehot       = NCH'(1) << channel_selector;

  // ==========================================================
  // command register
  logic [7:CMD_STORED_LSB] command_q;   // bits 1:0 are not kept
  logic                    ack_polarity;
  logic                    request_polarity;
  logic                    arbitration_scheme;
  logic                    group_disable;

  // bits 1:0 are not stored, so bit 1 has no effect
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      command_q <= COMMAND_RESET;
    end else if (full_reset) begin
      command_q <= COMMAND_RESET;
    end else if (wr_command) begin
      command_q <= io_wdata[7:CMD_STORED_LSB];
    end
  end

  assign ack_polarity       = command_q[CMD_ACK_POL];
  assign request_polarity   = command_q[CMD_REQ_POL];
  assign arbitration_scheme = command_q[CMD_ROTATE];
  assign group_disable      = command_q[CMD_DISABLE];

  // ==========================================================
  // masks
  logic [NCH-1:0] mask_q;          // 1 = masked
  logic [NCH-1:0] mask_d;

  always_comb begin
    mask_d = mask_q;
    if (full_reset) begin
      mask_d = MASK_RESET;
    end else if (unmask_all_strobe) begin
      mask_d = '0;
    end else if (wr_all_mask) begin
      mask_d = io_wdata[ALL_MASK_MSB:0];
    end else if (wr_single_mask) begin
      if (io_wdata[REQ_BIT]) begin
        mask_d = mask_q | sel_onehot;
      end else begin
        mask_d = mask_q & ~sel_onehot;
      end
    end
  end

  // mask register, all masked after reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) mask_q <= MASK_RESET;
    else          mask_q <= mask_d;
  end

  // ==========================================================
  // software requests
  logic [NCH-1:0] soft_req_q;
  logic [NCH-1:0] soft_req_d;

  always_comb begin
    soft_req_d = soft_req_q;
    if (full_reset) begin
      soft_req_d = '0;
    end else if (wr_soft_req) begin
      if (io_wdata[REQ_BIT]) begin
        soft_req_d = soft_req_q | sel_onehot;
      end else begin
        soft_req_d = soft_req_q & ~sel_onehot;
      end
    end
  end

  // software request flags
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) soft_req_q <= '0;
    else          soft_req_q <= soft_req_d;
  end

  // ==========================================================
  // per-channel mode
  logic [2*NCH-1:0] mode_q;         // transfer_mode_field per channel
  logic [NCH-1:0]   dir_q;          // address decrement per channel
  logic [NCH-1:0]   auto_q;         // auto-initialize per channel
  logic [2*NCH-1:0] type_q;         // transfer_type_field per channel

  // only the selected channel's fields are loaded
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= '0;
      dir_q  <= '0;
      auto_q <= '0;
      type_q <= '0;
    end else if (full_reset) begin
      mode_q <= '0;
      dir_q  <= '0;
      auto_q <= '0;
      type_q <= '0;
    end else if (wr_mode) begin
      mode_q[2*channel_selector +: 2] <=
        io_wdata[MODE_MODE_MSB:MODE_MODE_LSB];
      dir_q[channel_selector]  <= io_wdata[MODE_DIR];
      auto_q[channel_selector] <= io_wdata[MODE_AUTO];
      type_q[2*channel_selector +: 2] <=
        io_wdata[MODE_TYPE_MSB:MODE_TYPE_LSB];
    end
  end

  // ==========================================================
  // byte pointer
  logic byte_ptr_q;                 // 0 = low byte next

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      byte_ptr_q <= 1'b0;
    end else if (wr_ptr_clear || full_reset) begin
      byte_ptr_q <= 1'b0;
    end else if (xfer_access) begin
      byte_ptr_q <= !byte_ptr_q;
    end
  end

  // ==========================================================
  // request synchroniser and pending flags
  logic [NCH-1:0] req_meta_q;       // first stage, read by second only
  logic [NCH-1:0] req_sync_q;
  logic [NCH-1:0] hw_req;           // sensed hardware request
  logic [NCH-1:0] pending;          // request pending per channel

  // two-flop synchroniser on the request pins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_meta_q <= '0;
      req_sync_q <= '0;
    end else begin
      req_meta_q <= dma_request_line;
      req_sync_q <= req_meta_q;
    end
  end

  assign hw_req  = request_polarity ? ~req_sync_q : req_sync_q;
  assign pending = hw_req | soft_req_q;

  // ==========================================================
  // terminal count flags
  logic [NCH-1:0] tc_q;

  // set by count done, cleared by status read; set wins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n)        tc_q <= '0;
    else if (full_reset) tc_q <= chan_count_done;
    else if (rd_status)  tc_q <= chan_count_done;
    else                 tc_q <= tc_q | chan_count_done;
  end

  // ==========================================================
  // arbitration
  logic [NCH-1:0] eligible;         // pending, unmasked, enabled
  logic [NCH-1:0] grant_q;          // one-hot granted channel
  logic [NCH-1:0] grant_d;
  logic [1:0]     last_q;           // last granted channel
  logic [1:0]     start;            // highest priority this round

  // first eligible channel at or after start, wrapping
  function automatic logic [NCH-1:0] pick(input logic [NCH-1:0] req,
                                          input logic [1:0] first);
    logic [NCH-1:0] res;
    logic [1:0]     idx;
    res = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      idx = first + 2'(i);
      if (req[idx]) res = NCH'(1) << idx;
    end
    return res;
  endfunction : pick

  assign eligible = pending & ~mask_q & {NCH{!group_disable}};
  // fixed: channel 4 first; rotating: after last served
  assign start    = arbitration_scheme ? last_q + 2'h1 : 2'h0;
  assign grant_d  = |(grant_q & eligible) ? grant_q
                                          : pick(eligible, start);

  // grant held while the served channel stays eligible
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_q <= '0;
      last_q  <= '0;
    end else begin
      grant_q <= grant_d;
      for (int i = 0; i < NCH; i++) begin
        if (grant_d[i] && !grant_q[i]) last_q <= 2'(i);
      end
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      dma_acknowledge <= '1;
      io_rdata        <= READ_IDLE;
    end else begin
      // low-active acknowledge idles high
      dma_acknowledge <= ack_polarity ? grant_d : ~grant_d;
      if (rd_status) io_rdata <= {pending, tc_q};
      else           io_rdata <= READ_IDLE;
    end
  end

  assign chan_granted        = grant_q;
  assign extended_write      = command_q[CMD_EXT_WRITE];
  assign cycle_compression   = command_q[CMD_COMPRESS];
  assign byte_pointer_high   = byte_ptr_q;
  assign transfer_mode_field = mode_q;
  assign address_decrement   = dir_q;
  assign auto_init_enable    = auto_q;
  assign transfer_type_field = type_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence mask_write_s;
    wr_all_mask && !full_reset && !unmask_all_strobe;
  endsequence

  ack_polarity_a: assert property (1'b1 |=>
    (dma_acknowledge == (ack_polarity ? grant_q : ~grant_q)) ||
    $changed(ack_polarity))
    else $error("acknowledge level does not follow polarity");
  disable_blocks_a: assert property (group_disable |-> ##1
    (grant_q == '0))
    else $error("grant while group disabled");
  masked_no_grant_a: assert property (
    (grant_q & mask_q) == '0 || $past(mask_d) != $past(mask_q))
    else $error("masked channel granted");
  all_mask_load_a: assert property (mask_write_s |=>
    mask_q == $past(io_wdata[ALL_MASK_MSB:0]))
    else $error("all-mask write not loaded");
  unmask_all_a: assert property (unmask_all_strobe && !full_reset
    |=> mask_q == '0)
    else $error("unmask all left a mask set");
  full_reset_a: assert property (full_reset |=>
    (mask_q == MASK_RESET) && (command_q == COMMAND_RESET) &&
    (soft_req_q == '0) && !byte_ptr_q)
    else $error("full reset incomplete");
  ptr_clear_a: assert property (wr_ptr_clear |=> !byte_ptr_q)
    else $error("byte pointer not cleared");
  ptr_toggle_a: assert property (xfer_access && !wr_ptr_clear
    && !full_reset |=> byte_ptr_q != $past(byte_ptr_q))
    else $error("byte pointer did not step");
  soft_req_set_a: assert property (wr_soft_req && !full_reset &&
    io_wdata[REQ_BIT] |=> (|(soft_req_q & $past(sel_onehot))))
    else $error("software request not raised");
  status_read_a: assert property (rd_status |=>
    io_rdata == {$past(pending), $past(tc_q)})
    else $error("status byte wrong");
endmodule : upper_dma_channel_control

// ---- verilog/upper_dma_pkg.sv ----
// constants shared by the upper dma channel control block
package upper_dma_pkg;
  // ==========================================================
  // i/o addresses
  localparam int           ADDR_W           = 16;
  localparam logic [15:0]  ADDR_COMMAND     = 16'h00D0;
  localparam logic [15:0]  ADDR_SOFT_REQ    = 16'h00D2;
  localparam logic [15:0]  ADDR_SINGLE_MASK = 16'h00D4;
  localparam logic [15:0]  ADDR_MODE        = 16'h00D6;
  localparam logic [15:0]  ADDR_PTR_CLEAR   = 16'h00D8;
  localparam logic [15:0]  ADDR_FULL_RESET  = 16'h00DA;
  localparam logic [15:0]  ADDR_UNMASK_ALL  = 16'h00DC;
  localparam logic [15:0]  ADDR_ALL_MASK    = 16'h00DE;
  // address and count byte registers span this window
  localparam logic [15:0]  ADDR_XFER_LO     = 16'h00C0;
  localparam logic [15:0]  ADDR_XFER_HI     = 16'h00CE;
  // ==========================================================
  // command bit positions
  localparam int           CMD_ACK_POL      = 7;
  localparam int           CMD_REQ_POL      = 6;
  localparam int           CMD_EXT_WRITE    = 5;
  localparam int           CMD_ROTATE       = 4;
  localparam int           CMD_COMPRESS     = 3;
  localparam int           CMD_DISABLE      = 2;
  localparam int           CMD_STORED_LSB   = 2;
  // ==========================================================
  // request, mask and mode byte fields
  localparam int           SEL_MSB          = 1;
  localparam int           SEL_LSB          = 0;
  localparam int           REQ_BIT          = 2;
  localparam int           MODE_MODE_MSB    = 7;
  localparam int           MODE_MODE_LSB    = 6;
  localparam int           MODE_DIR         = 5;
  localparam int           MODE_AUTO        = 4;
  localparam int           MODE_TYPE_MSB    = 3;
  localparam int           MODE_TYPE_LSB    = 2;
  localparam int           ALL_MASK_MSB     = 3;
  localparam int           STS_REQ_LSB      = 4;
  // ==========================================================
  // reset values
  localparam logic [5:0]   COMMAND_RESET    = 6'h00;
  localparam logic [3:0]   MASK_RESET       = 4'hF;
  localparam logic [7:0]   READ_IDLE        = 8'h00;
  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    XFER_DEMAND  = 2'h0,
    XFER_SINGLE  = 2'h1,
    XFER_BLOCK   = 2'h2,
    XFER_CASCADE = 2'h3
  } xfer_mode_t;
  typedef enum logic [1:0] {
    TYPE_VERIFY  = 2'h0,
    TYPE_MEM_WR  = 2'h1,
    TYPE_MEM_RD  = 2'h2,
    TYPE_RSVD    = 2'h3
  } xfer_type_t;
endpackage : upper_dma_pkg
